// [afm_consts.svh]
// timing counts and status bit positions for the fault monitor
`ifndef AFM_CONSTS_SVH
`define AFM_CONSTS_SVH
`define AFM_CLK_MHZ 125
`define AFM_PEAK_TIME_MS 1000
`define AFM_PEAK_CYCLES (`AFM_PEAK_TIME_MS * 1000 * `AFM_CLK_MHZ)
`define AFM_ST_OC 0
`define AFM_ST_OV 1
`define AFM_ST_ABORT 2
`define AFM_ST_LATCH_LO 6
`define AFM_ST_LATCH_HI 7
`define AFM_ROUTE_NONE 2'h0
`define AFM_ROUTE_IN7 2'h1
`define AFM_ROUTE_ABORT 2'h2
`endif

// [afm_pkg.sv]
// types for the fault monitor
package afm_pkg;
  typedef enum logic [1:0] {AFM_PEAK_OK, AFM_PEAK_CAPPED} afm_peak_t;
endpackage

// [afm_stage_model.sv]
// power stage model driving the fault sense pins
`timescale 1ns/1ps
module afm_stage_model (
  // clock
  input wire logic clk,
  // fault requests
  input wire logic [1:0] short_req,
  input wire logic surge_req,
  // sense pins
  output logic [1:0] oc_line,
  output logic ov_line
);
  // pins held while the fault lasts; the enable is not looked at
  always @(posedge clk)
  begin
    oc_line <= short_req;
    ov_line <= surge_req;
  end
endmodule

// [afm_top.sv]
// amplifier fault supervision and torque limiting
`timescale 1ns/1ps
`include "afm_consts.svh"
//
// Operation
// - peak torque allowed at most one second
// - then cap continuous; low time refills budget
// - over-current disables amplifier and flags fault
// - no jumper: no controller action on over-current
// - input-seven route: drive input, run handler
// - abort route: assert abort on over-current
// - over-current stays latched until clear sequence
// - over-voltage flags, stops current, shorts phases
// - over-voltage recovers automatically, never latches
// - lockout jumper: abort disables stage, latches
// - non-latching faults reported live
// - latch only while bank has servo-active axis
// - status query returns eight-bit fault mask
// - fault starts handler routine when present
module afm_top #(
  parameter int TW = 16,
  parameter int PEAK_CYCLES = `AFM_PEAK_CYCLES
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // torque
  input wire logic [TW-1:0] TORQUE_COMMAND_VALUE,
  input wire logic [TW-1:0] PEAK_TORQUE_LIMIT,
  input wire logic [TW-1:0] CONTINUOUS_TORQUE_CAP,
  output logic [TW-1:0] TORQUE_OUT,
  // amplifier pins; fault line and enable per bank (bit0 A-D, bit1 E-H), others shared
  input wire logic [1:0] OVERCURRENT_FAULT_LINE,
  input wire logic OVERVOLT_IN,
  input wire logic ABORT_IN,
  output logic [1:0] STAGE_ENABLE,
  output logic PHASE_SHORT,
  // configuration
  input wire logic [1:0] OVERCURRENT_ROUTE_JUMPER,
  input wire logic EMERGENCY_LOCKOUT_JUMPER,
  input wire logic INPUT_POLARITY_CONFIG,
  input wire logic FAULT_HANDLER_ARM,
  input wire logic FAULT_HANDLER_ROUTINE,
  input wire logic [1:0] SERVO_ACTIVE,
  input wire logic [1:0] DRIVE_DISABLE_CMD,
  input wire logic [1:0] SERVO_HOLD_CMD,
  // controller side
  output logic GENERAL_INPUT_SEVEN,
  output logic ABORT_INPUT,
  output logic HANDLER_START,
  // status port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic IRQ
);
  localparam logic [3:0] A_STAT = 4'h0;
  localparam logic [3:0] A_IRQ = 4'h1;
  localparam logic [3:0] A_MASK = 4'h2;
  localparam logic [31:0] PEAK_N = 32'(PEAK_CYCLES);

  // pin synchronisers, first stage read only by the second
  // costs two cycles of fault latency, buys freedom from metastability
  logic [3:0] s1_q, s2_q, s1_d;
  always_comb s1_d = {ABORT_IN, OVERVOLT_IN, OVERCURRENT_FAULT_LINE};
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s1_q;
    end
  end
  logic [1:0] oc;
  logic ov, ab;
  always_comb
  begin
    oc = s2_q[1:0];
    ov = s2_q[2];
    ab = s2_q[3];
  end

  // peak budget: drains above cap, refills below cap
  // one count per cycle, so a full refill lasts as long as the peak itself
  // exactly at the cap the budget neither drains nor refills
  logic [31:0] bud_q, bud_d;
  afm_pkg::afm_peak_t pk_q, pk_d;
  logic [TW-1:0] tq_d, tq_q;
  always_comb
  begin
    bud_d = bud_q;
    pk_d = pk_q;
    if (TORQUE_COMMAND_VALUE > CONTINUOUS_TORQUE_CAP)
    begin
      if (bud_q != 32'h0) bud_d = bud_q - 32'h1;
    end
    else if (TORQUE_COMMAND_VALUE < CONTINUOUS_TORQUE_CAP && bud_q < PEAK_N)
      bud_d = bud_q + 32'h1;
    unique case (pk_q)
      afm_pkg::AFM_PEAK_OK: if (bud_d == 32'h0) pk_d = afm_pkg::AFM_PEAK_CAPPED;
      afm_pkg::AFM_PEAK_CAPPED: if (bud_d == PEAK_N) pk_d = afm_pkg::AFM_PEAK_OK;
    endcase
    tq_d = TORQUE_COMMAND_VALUE;
    if (tq_d > PEAK_TORQUE_LIMIT) tq_d = PEAK_TORQUE_LIMIT;
    if (pk_q == afm_pkg::AFM_PEAK_CAPPED && tq_d > CONTINUOUS_TORQUE_CAP)
      tq_d = CONTINUOUS_TORQUE_CAP;
    if (ov) tq_d = '0;
  end
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      bud_q <= PEAK_N;
      pk_q <= afm_pkg::AFM_PEAK_OK;
      tq_q <= '0;
    end
    else
    begin
      bud_q <= bud_d;
      pk_q <= pk_d;
      tq_q <= tq_d;
    end
  end

  // per-bank latching: over-current and lockout abort
  logic [1:0] oc_lat_q, oc_lat_d, ab_lat_q, ab_lat_d, clr_arm_q, clr_arm_d, clr;
  always_comb
  begin
    for (int b = 0; b < 2; b++)
    begin
      clr_arm_d[b] = clr_arm_q[b];
      clr[b] = 1'b0;
      if (DRIVE_DISABLE_CMD[b]) clr_arm_d[b] = 1'b1;
      else if (SERVO_HOLD_CMD[b] && clr_arm_q[b])
      begin
        clr[b] = 1'b1;
        clr_arm_d[b] = 1'b0;
      end
      // set wins over clear; each bank alone
      oc_lat_d[b] = oc_lat_q[b];
      ab_lat_d[b] = ab_lat_q[b];
      if (clr[b]) oc_lat_d[b] = 1'b0;
      if (clr[b]) ab_lat_d[b] = 1'b0;
      if (oc[b] && SERVO_ACTIVE[b]) oc_lat_d[b] = 1'b1;
      if (ab && EMERGENCY_LOCKOUT_JUMPER && SERVO_ACTIVE[b]) ab_lat_d[b] = 1'b1;
    end
  end
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      oc_lat_q <= 2'h0;
      ab_lat_q <= 2'h0;
      clr_arm_q <= 2'h0;
    end
    else
    begin
      oc_lat_q <= oc_lat_d;
      ab_lat_q <= ab_lat_d;
      clr_arm_q <= clr_arm_d;
    end
  end

  // amplifier and controller-side outputs
  logic [1:0] en_d;
  logic in7_d, abo_d, hs_d, fault_now, fault_prev_q;
  logic [7:0] st_live;
  always_comb
  begin
    en_d = ~(oc_lat_q | oc | ab_lat_q);
    in7_d = (OVERCURRENT_ROUTE_JUMPER == `AFM_ROUTE_IN7) && (|oc);
    abo_d = (OVERCURRENT_ROUTE_JUMPER == `AFM_ROUTE_ABORT) && (|oc);
    st_live = 8'h00;
    st_live[`AFM_ST_OC] = |oc_lat_q;
    st_live[`AFM_ST_OV] = ov;
    st_live[`AFM_ST_ABORT] = |ab_lat_q;
    st_live[`AFM_ST_LATCH_LO] = oc_lat_q[0] | ab_lat_q[0];
    st_live[`AFM_ST_LATCH_HI] = oc_lat_q[1] | ab_lat_q[1];
    // over-voltage and lockout abort always reach the handler
    fault_now = ov | (|ab_lat_q);
    // unrouted or unarmed over-current stays invisible to the program
    if ((OVERCURRENT_ROUTE_JUMPER == `AFM_ROUTE_IN7) && FAULT_HANDLER_ARM &&
      INPUT_POLARITY_CONFIG)
      fault_now = fault_now | (|oc_lat_q);
    // one pulse per rising fault, so the handler is not re-entered
    hs_d = FAULT_HANDLER_ROUTINE && fault_now && !fault_prev_q;
  end

  // status, mask, event flags; read of flags clears them
  logic [7:0] irq_st_q, irq_st_d, mask_q, mask_d, rd_d, rd_q;
  logic irq_d;
  always_comb
  begin
    irq_st_d = irq_st_q;
    if (RD && ADDR == A_IRQ) irq_st_d = 8'h00;
    irq_st_d = irq_st_d | st_live;
    mask_d = mask_q;
    if (WR && ADDR == A_MASK) mask_d = WDATA;
    unique case (ADDR)
      A_STAT: rd_d = st_live;
      A_IRQ: rd_d = irq_st_q;
      A_MASK: rd_d = mask_q;
      default: rd_d = 8'h00;
    endcase
    if (!RD) rd_d = 8'h00;
    irq_d = |(irq_st_d & mask_d);
  end
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      STAGE_ENABLE <= 2'h0;
      PHASE_SHORT <= 1'b0;
      GENERAL_INPUT_SEVEN <= 1'b0;
      ABORT_INPUT <= 1'b0;
      HANDLER_START <= 1'b0;
      fault_prev_q <= 1'b0;
      irq_st_q <= 8'h00;
      mask_q <= 8'h00;
      rd_q <= 8'h00;
      IRQ <= 1'b0;
    end
    else
    begin
      STAGE_ENABLE <= en_d;
      PHASE_SHORT <= ov;
      GENERAL_INPUT_SEVEN <= in7_d;
      ABORT_INPUT <= abo_d;
      HANDLER_START <= hs_d;
      fault_prev_q <= fault_now;
      irq_st_q <= irq_st_d;
      mask_q <= mask_d;
      rd_q <= rd_d;
      IRQ <= irq_d;
    end
  end
  always_comb RDATA = rd_q;
  always_comb TORQUE_OUT = tq_q;

  // torque and over-voltage checks
  AST_OV_SHORT: assert property (@(posedge CORE_CLK) disable iff (SRST)
    ov |=> PHASE_SHORT && TORQUE_OUT == '0) else $error("ov no short");
  AST_OV_RECOVER: assert property (@(posedge CORE_CLK) disable iff (SRST)
    $fell(ov) |=> !PHASE_SHORT) else $error("ov stuck");

  // over-current and lockout checks
  AST_OC_DISABLE: assert property (@(posedge CORE_CLK) disable iff (SRST)
    oc[0] |=> !STAGE_ENABLE[0]) else $error("oc enabled");
  AST_LOCKOUT: assert property (@(posedge CORE_CLK) disable iff (SRST)
    ab_lat_q[0] |=> !STAGE_ENABLE[0]) else $error("lockout enabled");
  AST_OC_HOLD: assert property (@(posedge CORE_CLK) disable iff (SRST)
    oc_lat_q[0] && !clr[0] |=> oc_lat_q[0]) else $error("oc dropped");

  // routing checks
  AST_NO_ROUTE: assert property (@(posedge CORE_CLK) disable iff (SRST)
    OVERCURRENT_ROUTE_JUMPER == `AFM_ROUTE_NONE |=> !GENERAL_INPUT_SEVEN && !ABORT_INPUT)
    else $error("unrouted action");
  AST_IN7: assert property (@(posedge CORE_CLK) disable iff (SRST)
    OVERCURRENT_ROUTE_JUMPER == `AFM_ROUTE_IN7 && oc[1] |=> GENERAL_INPUT_SEVEN)
    else $error("in7 missing");
  AST_ABORT: assert property (@(posedge CORE_CLK) disable iff (SRST)
    OVERCURRENT_ROUTE_JUMPER == `AFM_ROUTE_ABORT && oc[0] |=> ABORT_INPUT)
    else $error("abort missing");

  // bank checks
  AST_NO_LATCH_IDLE: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !oc_lat_q[1] && !SERVO_ACTIVE[1] |=> !oc_lat_q[1]) else $error("latched idle");
  AST_BANK_INDEP: assert property (@(posedge CORE_CLK) disable iff (SRST)
    clr[0] && !clr[1] && oc_lat_q[1] |=> oc_lat_q[1]) else $error("bank leak");

  // status port checks
  AST_RD_IDLE: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !RD |=> RDATA == 8'h00) else $error("read data without read");
  AST_OV_LIVE: assert property (@(posedge CORE_CLK) disable iff (SRST)
    RD && ADDR == A_STAT |=> RDATA[`AFM_ST_OV] == $past(ov)) else $error("ov not live");
  AST_BANK_REPORT: assert property (@(posedge CORE_CLK) disable iff (SRST)
    RD && ADDR == A_STAT |=> RDATA[`AFM_ST_LATCH_HI] == $past(oc_lat_q[1] | ab_lat_q[1]))
    else $error("bank bit wrong");

  // torque budget checks
  AST_CAP: assert property (@(posedge CORE_CLK) disable iff (SRST)
    pk_q == afm_pkg::AFM_PEAK_CAPPED && !ov |=> TORQUE_OUT <= CONTINUOUS_TORQUE_CAP)
    else $error("cap exceeded");
  AST_PEAK: assert property (@(posedge CORE_CLK) disable iff (SRST)
    ##1 TORQUE_OUT <= $past(PEAK_TORQUE_LIMIT)) else $error("peak exceeded");

  // scenario covers
  COV_OC: cover property (@(posedge CORE_CLK) oc_lat_q[0] ##[1:20] clr[0]);
  COV_CAP: cover property (@(posedge CORE_CLK) pk_q == afm_pkg::AFM_PEAK_CAPPED);
  COV_OV: cover property (@(posedge CORE_CLK) PHASE_SHORT ##1 !PHASE_SHORT);
  COV_HS: cover property (@(posedge CORE_CLK) HANDLER_START);
  COV_ABORT: cover property (@(posedge CORE_CLK) ab_lat_q[0]);
endmodule

// [afm_top_bench.sv]
// self-checking bench for the fault monitor
`timescale 1ns/1ps
module afm_top_bench;
  localparam int PK = 50;
  logic clk = 0;
  logic srst = 1;
  logic [15:0] cmd = 0, peak = 16'h00C8, cap = 16'h0064, tq;
  logic [1:0] short_req = 0, oc, en, sact = 0, ddis = 0, shold = 0, route = 0;
  logic surge = 0, ov, psh, abt = 0, emergency_lockout_jumper = 0, in7, abo, hst, irq, wr = 0, rd = 0;
  logic [3:0] addr = 0;
  logic [7:0] wd = 0, rdat, d;
  int failures = 0, compares = 0, cyc = 0, hcount = 0, h0 = 0, bud = PK;
  bit capped = 0;
  logic arm = 1;
  // motor type and bypass are host setup, no pin of this block
  always #4 clk = ~clk;
  afm_top #(.PEAK_CYCLES(PK)) i_afm_top (.CORE_CLK(clk), .SRST(srst),
    .TORQUE_COMMAND_VALUE(cmd), .PEAK_TORQUE_LIMIT(peak), .CONTINUOUS_TORQUE_CAP(cap),
    .TORQUE_OUT(tq), .OVERCURRENT_FAULT_LINE(oc), .OVERVOLT_IN(ov), .ABORT_IN(abt),
    .STAGE_ENABLE(en), .PHASE_SHORT(psh), .OVERCURRENT_ROUTE_JUMPER(route),
    .EMERGENCY_LOCKOUT_JUMPER(emergency_lockout_jumper), .INPUT_POLARITY_CONFIG(1'b1), .FAULT_HANDLER_ARM(arm),
    .FAULT_HANDLER_ROUTINE(1'b1), .SERVO_ACTIVE(sact), .DRIVE_DISABLE_CMD(ddis),
    .SERVO_HOLD_CMD(shold), .GENERAL_INPUT_SEVEN(in7), .ABORT_INPUT(abo),
    .HANDLER_START(hst), .ADDR(addr), .WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdat), .IRQ(irq));
  afm_stage_model i_afm_stage_model (.clk(clk), .short_req(short_req), .surge_req(surge),
    .oc_line(oc), .ov_line(ov));
  // budget model: drains above the cap, refills below, capped until full
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (hst === 1'b1) hcount <= hcount + 1;
    if (srst) bud <= PK;
    else if (cmd > cap && bud > 0) bud <= bud - 1;
    else if (cmd < cap && bud < PK) bud <= bud + 1;
    if (bud == 0) capped <= 1;
    else if (bud == PK) capped <= 0;
    if (cyc == 20000)
    begin
      failures++;
      test_done();
    end
  end
  function automatic logic [15:0] etq();
    logic [15:0] t;
    t = (cmd < peak) ? cmd : peak;
    return (capped && t > cap) ? cap : t;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one-cycle strobes; read data stand in the following cycle
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wd <= v;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    @(posedge clk);
    d = rdat;
  endtask
  // drive-off then servo-hold on one bank, axes already halted
  task automatic clr(input int b);
    @(posedge clk);
    ddis <= 2'(1 << b);
    @(posedge clk);
    ddis <= 0;
    @(posedge clk);
    shold <= 2'(1 << b);
    @(posedge clk);
    shold <= 0;
    tick(5);
  endtask
  task automatic test_done();
    $display("counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial
  begin
    void'($urandom(32'hFA93));
    tick(8);
    chk(en, 0);
    srst <= 0;
    tick(4);
    chk(en, 3);
    cmd <= 16'h00FA;
    tick(20);
    chk(tq, etq());
    tick(50);
    chk(tq, etq());
    cmd <= 16'($urandom % 100);
    tick(40);
    chk(tq, etq());
    cmd <= 16'h00FA;
    tick(3);
    chk(tq, 16'h0064);
    cmd <= 16'h000A;
    tick(60);
    cmd <= 16'h00FA;
    tick(5);
    chk(tq, 16'h00C8);
    $display("torque test done");
    wr_reg(2, 8'hFF);
    rd_reg(2);
    chk(d, 8'hFF);
    rd_reg(1);
    surge <= 1;
    tick(5);
    chk(tq, 0);
    chk(psh, 1);
    rd_reg(0);
    chk(d[1], 1);
    surge <= 0;
    tick(5);
    chk(psh, 0);
    chk(irq, 1);
    rd_reg(1);
    chk(d[1], 1);
    tick(2);
    chk(irq, 0);
    rd_reg(0);
    chk(d, 0);
    rd_reg(4'hF);
    chk(d, 0);
    wr_reg(4'hF, 8'h55);
    wr_reg(2, 8'h00);
    rd_reg(2);
    chk(d, 0);
    $display("status test done");
    sact <= 3;
    // r = 3 is the input-seven route with the handler left unarmed
    for (int r = 0; r < 4; r++)
    begin
      route <= (r == 3) ? 2'h1 : 2'(r);
      arm <= (r != 3);
      h0 = hcount;
      short_req <= 1;
      tick(5);
      chk(en, 2);
      chk(in7, r == 1 || r == 3);
      chk(abo, r == 2);
      short_req <= 0;
      tick(5);
      if (r != 2) chk(hcount != h0, r == 1);
      rd_reg(0);
      chk(d, 8'h41);
      chk(en, 2);
      clr(0);
      rd_reg(0);
      chk(d, 0);
      chk(en, 3);
    end
    short_req <= 2;
    tick(5);
    short_req <= 0;
    clr(0);
    rd_reg(0);
    chk(d, 8'h81);
    clr(1);
    sact <= 0;
    short_req <= 2;
    tick(5);
    short_req <= 0;
    tick(5);
    rd_reg(0);
    chk(d, 0);
    chk(en, 3);
    sact <= 3;
    emergency_lockout_jumper <= 1;
    abt <= 1;
    tick(5);
    abt <= 0;
    tick(5);
    chk(en, 0);
    rd_reg(0);
    chk(d[2], 1);
    chk(irq, 0);
    $display("fault test done");
    test_done();
  end
endmodule
